// *** src/smd_pkg.sv ***
// Empty by design: the constants package of the sync mark detector is defined in smd_detector.sv

// *** src/smd_fifo.sv ***
// Empty by design: the stream buffer module of the sync mark detector is defined in smd_detector.sv

// *** src/smd_detector.sv ***
// Sync mark detector with its constants and stream buffer: mark search, delayed data, strobe, spare latch
`timescale 1ns/1ps

package smd_pkg;

  // ==========================================================
  // Shift register and pattern
  localparam int unsigned SR_WIDTH     = 8;
  localparam int unsigned SR_MSB       = SR_WIDTH - 1;
  localparam logic [7:0]  MARK_DATA    = 8'ha1;
  localparam logic [7:0]  MARK_CLOCK   = 8'h0a;

  // ==========================================================
  // Input synchroniser slots
  localparam int unsigned SYN_W        = 7;
  localparam int unsigned SYN_EN       = 0;
  localparam int unsigned SYN_RCLK     = 1;
  localparam int unsigned SYN_RCLK_N   = 2;
  localparam int unsigned SYN_DATA     = 3;
  localparam int unsigned SYN_CPULSE   = 4;
  localparam int unsigned SYN_SPCLK    = 5;
  localparam int unsigned SYN_SPCLR_N  = 6;
  // Clear input of the spare latch idles high
  localparam logic [6:0]  SYN_RST      = 7'h40;

  // ==========================================================
  // Stream buffer
  localparam int unsigned BUF_WIDTH    = 1;
  localparam int unsigned BUF_DEPTH    = 8;

  // ==========================================================
  // Output idle levels
  localparam logic        LVL_LOW      = 1'b0;
  localparam logic        LVL_HIGH     = 1'b1;

endpackage

module smd_fifo #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             ce_i,
  input  wire logic             flush_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [CW-1:0]               cnt;
  } smd_fifo_s;

  smd_fifo_s q_r;
  smd_fifo_s q_nxt;
  logic      push;
  logic      pop;

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  assign in_ready_o  = (q_r.cnt != CW'(DEPTH));
  assign out_valid_o = (q_r.cnt != '0);
  assign out_data_o  = q_r.mem[q_r.rd];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_comb begin
    q_nxt = q_r;
    if (flush_i) begin
      q_nxt.wr  = '0;
      q_nxt.rd  = '0;
      q_nxt.cnt = '0;
    end else begin
      if (push) begin
        q_nxt.mem[q_r.wr] = in_data_i;
        q_nxt.wr          = wrap_inc(q_r.wr);
      end
      if (pop) begin
        q_nxt.rd = wrap_inc(q_r.rd);
      end
      q_nxt.cnt = q_r.cnt + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_r <= '0;
    end else if (ce_i) begin
      q_r <= q_nxt;
    end
  end

endmodule

// ==========================================================
// Overview of operation
// - Both pulse inputs are clocked in by the complementary read clocks.
// - Search enable low stops shifting and idles mark, strobe and data outputs.
// - Data bit shifts in on the falling edge of the inverted read clock.
// - Clock pulse bit shifts in on the falling edge of the true read clock.
// - Serial data output is the last data stage, seven bits late.
// - Each shift compares both registers against data A1 and clock 0A.
// - On a match the low mark output drops and the high one rises.
// - Mark outputs stay latched until search enable goes low again.
// - After a mark the strobe toggles in step with serial data.
// - Rising spare latch clock sets the spare latch output low.
// - Low spare latch clear forces the spare output high, as a level.
// - Low test pulses mark a data A1 match and a clock 0A match.
module smd_detector (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  input  wire logic search_enable_i,
  input  wire logic read_clk_i,
  input  wire logic read_clk_n_i,
  input  wire logic data_pulse_i,
  input  wire logic clock_pulse_i,
  input  wire logic spare_latch_clock_i,
  input  wire logic spare_latch_clear_n_i,
  input  wire logic stream_ready_i,
  output logic      serial_data_o,
  output logic      serial_out_strobe_o,
  output logic      mark_found_o,
  output logic      mark_found_n_o,
  output logic      data_match_pulse_n_o,
  output logic      clock_match_pulse_n_o,
  output logic      spare_latch_out_o,
  output logic      stream_valid_o,
  output logic      stream_bit_o,
  output logic      stream_overrun_o
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [smd_pkg::SYN_W-1:0]    syn1;
    logic [smd_pkg::SYN_W-1:0]    syn2;
    logic                         rclk_prev;
    logic                         rclk_n_prev;
    logic                         spclk_prev;
    logic [smd_pkg::SR_MSB:0]     data_sr;
    logic [smd_pkg::SR_MSB:0]     clk_sr;
    logic                         mark;
    logic                         mark_n;
    logic                         strobe;
    logic                         sdata;
    logic                         dmatch_n;
    logic                         cmatch_n;
    logic                         spare;
    logic                         st_valid;
    logic                         st_bit;
    logic                         overrun;
  } smd_state_s;

  smd_state_s q_r;
  smd_state_s q_nxt;

  // ==========================================================
  // Edge decode, used for both read clocks and the spare clock
  function automatic logic fell(input logic prev, input logic cur);
    fell = prev & ~cur;
  endfunction

  function automatic logic rose(input logic prev, input logic cur);
    rose = ~prev & cur;
  endfunction

  // ==========================================================
  // Buffer hookup
  logic buf_in_valid;
  logic buf_in_ready;
  logic buf_in_bit;
  logic buf_out_valid;
  logic buf_out_ready;
  logic buf_out_bit;
  logic buf_flush;

  // Stage register takes a word whenever it is empty or being drained
  assign buf_out_ready = ~q_r.st_valid | stream_ready_i;

  smd_fifo #(
    .WIDTH (smd_pkg::BUF_WIDTH),
    .DEPTH (smd_pkg::BUF_DEPTH)
  ) smd_fifo_i (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .flush_i     (buf_flush),
    .in_valid_i  (buf_in_valid),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (buf_in_bit),
    .out_valid_o (buf_out_valid),
    .out_ready_i (buf_out_ready),
    .out_data_o  (buf_out_bit)
  );

  // ==========================================================
  // Synchronised views, second stage only
  logic en_s;
  logic rclk_s;
  logic rclk_n_s;
  logic data_s;
  logic cpulse_s;
  logic spclk_s;
  logic spclr_n_s;

  assign en_s      = q_r.syn2[smd_pkg::SYN_EN];
  assign rclk_s    = q_r.syn2[smd_pkg::SYN_RCLK];
  assign rclk_n_s  = q_r.syn2[smd_pkg::SYN_RCLK_N];
  assign data_s    = q_r.syn2[smd_pkg::SYN_DATA];
  assign cpulse_s  = q_r.syn2[smd_pkg::SYN_CPULSE];
  assign spclk_s   = q_r.syn2[smd_pkg::SYN_SPCLK];
  assign spclr_n_s = q_r.syn2[smd_pkg::SYN_SPCLR_N];

  // ==========================================================
  // Shift events
  logic data_shift;
  logic clk_shift;
  logic any_shift;

  // Pulse inputs pass the same two stages as the read clocks, so the
  // level seen at a detected edge is the one present at that edge
  assign data_shift = en_s & fell(q_r.rclk_n_prev, rclk_n_s);
  assign clk_shift  = en_s & fell(q_r.rclk_prev, rclk_s);
  assign any_shift  = data_shift | clk_shift;

  assign buf_flush    = ~en_s;
  assign buf_in_valid = data_shift & q_r.mark;
  assign buf_in_bit   = q_r.data_sr[smd_pkg::SR_MSB - 1];

  // ==========================================================
  // Next state
  always_comb begin
    q_nxt = q_r;

    q_nxt.syn1        = {spare_latch_clear_n_i,
                         spare_latch_clock_i,
                         clock_pulse_i,
                         data_pulse_i,
                         read_clk_n_i,
                         read_clk_i,
                         search_enable_i};
    q_nxt.syn2        = q_r.syn1;
    q_nxt.rclk_prev   = rclk_s;
    q_nxt.rclk_n_prev = rclk_n_s;
    q_nxt.spclk_prev  = spclk_s;

    // Test pulses last one clock cycle per matching shift
    q_nxt.dmatch_n = smd_pkg::LVL_HIGH;
    q_nxt.cmatch_n = smd_pkg::LVL_HIGH;

    if (!en_s) begin
      // Initialise: no shifting, all search outputs idle
      q_nxt.data_sr  = '0;
      q_nxt.clk_sr   = '0;
      q_nxt.mark     = smd_pkg::LVL_LOW;
      q_nxt.mark_n   = smd_pkg::LVL_HIGH;
      q_nxt.strobe   = smd_pkg::LVL_LOW;
      q_nxt.sdata    = smd_pkg::LVL_LOW;
      q_nxt.st_valid = smd_pkg::LVL_LOW;
      q_nxt.overrun  = smd_pkg::LVL_LOW;
    end else begin
      if (data_shift) begin
        q_nxt.data_sr = {q_r.data_sr[smd_pkg::SR_MSB-1:0], data_s};
      end
      if (clk_shift) begin
        q_nxt.clk_sr = {q_r.clk_sr[smd_pkg::SR_MSB-1:0], cpulse_s};
      end

      // Last data stage, seven bit times behind the input
      q_nxt.sdata = q_nxt.data_sr[smd_pkg::SR_MSB];

      if (any_shift) begin
        if (q_nxt.data_sr == smd_pkg::MARK_DATA) begin
          q_nxt.dmatch_n = smd_pkg::LVL_LOW;
        end
        if (q_nxt.clk_sr == smd_pkg::MARK_CLOCK) begin
          q_nxt.cmatch_n = smd_pkg::LVL_LOW;
        end
        // Full 16-bit compare of both registers on every shift
        if ({q_nxt.data_sr, q_nxt.clk_sr} ==
            {smd_pkg::MARK_DATA, smd_pkg::MARK_CLOCK}) begin
          q_nxt.mark   = smd_pkg::LVL_HIGH;
          q_nxt.mark_n = smd_pkg::LVL_LOW;
        end
      end

      // Data moves near the rise of the true read clock, so the strobe
      // rises mid-bit on its fall and stays high while the read clock is low
      q_nxt.strobe = q_r.mark & ~rclk_s;

      // Disk data cannot be paused; a full buffer drops the bit and
      // latches an overrun until search enable goes low
      if (buf_in_valid && !buf_in_ready) begin
        q_nxt.overrun = smd_pkg::LVL_HIGH;
      end

      if (buf_out_valid && buf_out_ready) begin
        q_nxt.st_valid = smd_pkg::LVL_HIGH;
        q_nxt.st_bit   = buf_out_bit;
      end else if (stream_ready_i) begin
        q_nxt.st_valid = smd_pkg::LVL_LOW;
      end
    end

    // Spare latch: clear is a level and overrides the clock edge
    if (!spclr_n_s) begin
      q_nxt.spare = smd_pkg::LVL_HIGH;
    end else if (rose(q_r.spclk_prev, spclk_s)) begin
      q_nxt.spare = smd_pkg::LVL_LOW;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_r             <= '0;
      q_r.syn1        <= smd_pkg::SYN_RST;
      q_r.syn2        <= smd_pkg::SYN_RST;
      q_r.mark_n      <= smd_pkg::LVL_HIGH;
      q_r.dmatch_n    <= smd_pkg::LVL_HIGH;
      q_r.cmatch_n    <= smd_pkg::LVL_HIGH;
      q_r.spare       <= smd_pkg::LVL_HIGH;
    end else if (ce_i) begin
      q_r <= q_nxt;
    end
  end

  // ==========================================================
  // Outputs, all straight from the state register
  assign serial_data_o         = q_r.sdata;
  assign serial_out_strobe_o   = q_r.strobe;
  assign mark_found_o          = q_r.mark;
  assign mark_found_n_o        = q_r.mark_n;
  assign data_match_pulse_n_o  = q_r.dmatch_n;
  assign clock_match_pulse_n_o = q_r.cmatch_n;
  assign spare_latch_out_o     = q_r.spare;
  assign stream_valid_o        = q_r.st_valid;
  assign stream_bit_o          = q_r.st_bit;
  assign stream_overrun_o      = q_r.overrun;

endmodule

// *** tb/smd_asserts.sv ***
// Assertion checker for the sync mark detector ports
`timescale 1ns/1ps
module smd_asserts (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic search_enable_i,
  input wire logic read_clk_i,
  input wire logic spare_latch_clock_i,
  input wire logic spare_latch_clear_n_i,
  input wire logic serial_data_o,
  input wire logic serial_out_strobe_o,
  input wire logic mark_found_o,
  input wire logic mark_found_n_o,
  input wire logic data_match_pulse_n_o,
  input wire logic clock_match_pulse_n_o,
  input wire logic spare_latch_out_o
);
  // ====================
  // Sequences
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Four cycles cover the two-stage synchroniser plus the edge detect
  sequence s_search_on; search_enable_i[*4] ##0 mark_found_o; endsequence
  sequence s_search_off; (!search_enable_i)[*4]; endsequence
  sequence s_rd_low; (mark_found_o && search_enable_i && !read_clk_i)[*4]; endsequence
  sequence s_spare_rise; $rose(spare_latch_clock_i) ##0 spare_latch_clear_n_i[*6]; endsequence
  // ====================
  // Properties
  a_mark_pair: assert property (mark_found_o == !mark_found_n_o)
    else $error("mark outputs not complementary");
  a_mark_held: assert property (s_search_on |=> mark_found_o)
    else $error("mark dropped while searching");
  a_idle_off: assert property (s_search_off |=> !mark_found_o && !serial_out_strobe_o && !serial_data_o)
    else $error("outputs active while search off");
  a_mark_cause: assert property ($rose(mark_found_o) |-> !data_match_pulse_n_o && !clock_match_pulse_n_o)
    else $error("mark without both byte matches");
  a_data_pulse: assert property (!data_match_pulse_n_o |=> data_match_pulse_n_o)
    else $error("data match pulse too long");
  a_clock_pulse: assert property (!clock_match_pulse_n_o |=> clock_match_pulse_n_o)
    else $error("clock match pulse too long");
  a_strobe_mark: assert property (serial_out_strobe_o |-> mark_found_o)
    else $error("strobe before mark");
  a_strobe_low: assert property (s_rd_low |=> serial_out_strobe_o)
    else $error("strobe missing in read clock low");
  a_strobe_high: assert property (read_clk_i[*4] |=> !serial_out_strobe_o)
    else $error("strobe high in read clock high");
  a_spare_clear: assert property ((!spare_latch_clear_n_i)[*4] |=> spare_latch_out_o)
    else $error("spare latch not preset");
  a_spare_set: assert property (s_spare_rise |=> !spare_latch_out_o)
    else $error("spare latch not set low");
endmodule
bind smd_detector smd_asserts smd_asserts_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .search_enable_i(search_enable_i),
  .read_clk_i(read_clk_i), .spare_latch_clock_i(spare_latch_clock_i), .spare_latch_clear_n_i(spare_latch_clear_n_i),
  .serial_data_o(serial_data_o), .serial_out_strobe_o(serial_out_strobe_o), .mark_found_o(mark_found_o),
  .mark_found_n_o(mark_found_n_o), .data_match_pulse_n_o(data_match_pulse_n_o),
  .clock_match_pulse_n_o(clock_match_pulse_n_o), .spare_latch_out_o(spare_latch_out_o));

// *** tb/smd_sep_model.sv ***
// Data separator model driving read clocks and pulse lines
`timescale 1ns/1ps
module smd_sep_model (
  input  wire logic clk_i,
  output logic      read_clk_o,
  output logic      read_clk_n_o,
  output logic      data_pulse_o,
  output logic      clock_pulse_o
);
  // ====================
  // Frame driver
  // Read clock stands still between frames; one bit is 8 system clocks
  initial begin
    read_clk_o = 1'b0;
    read_clk_n_o = 1'b1;
    data_pulse_o = 1'b0;
    clock_pulse_o = 1'b0;
  end
  task automatic send(input logic [15:0] d, input logic [15:0] c, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk_i);
      data_pulse_o <= d[i];
      repeat (2) @(posedge clk_i);
      read_clk_o <= 1'b1;
      read_clk_n_o <= 1'b0;
      repeat (2) @(posedge clk_i);
      clock_pulse_o <= c[i];
      repeat (2) @(posedge clk_i);
      read_clk_o <= 1'b0;
      read_clk_n_o <= 1'b1;
      @(posedge clk_i);
    end
    // Released lines flip so a stale copy can never pass for data
    @(posedge clk_i);
    data_pulse_o <= ~data_pulse_o;
    clock_pulse_o <= ~clock_pulse_o;
  endtask
endmodule

// *** tb/smd_detector_tb.sv ***
// Self-checking bench for the sync mark detector
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module smd_detector_tb;
  // ====================
  // Signals
  logic clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, search_enable_i = 1'b0, stream_ready_i = 1'b0;
  logic spare_latch_clock_i = 1'b0, spare_latch_clear_n_i = 1'b1;
  logic read_clk_i, read_clk_n_i, data_pulse_i, clock_pulse_i, serial_data_o, serial_out_strobe_o;
  logic mark_found_o, mark_found_n_o, data_match_pulse_n_o, clock_match_pulse_n_o, spare_latch_out_o;
  logic stream_valid_o, stream_bit_o, stream_overrun_o;
  logic [15:0] post;
  logic        got[$];
  logic [2:0]  sp[5] = '{3'b110, 3'b001, 3'b101, 3'b011, 3'b110};
  int          n_mismatch = 0, n_checks = 0, n_dp = 0, n_cp = 0;
  smd_detector smd_detector_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .search_enable_i(search_enable_i),
    .read_clk_i(read_clk_i), .read_clk_n_i(read_clk_n_i), .data_pulse_i(data_pulse_i), .clock_pulse_i(clock_pulse_i),
    .spare_latch_clock_i(spare_latch_clock_i), .spare_latch_clear_n_i(spare_latch_clear_n_i),
    .stream_ready_i(stream_ready_i), .serial_data_o(serial_data_o), .serial_out_strobe_o(serial_out_strobe_o),
    .mark_found_o(mark_found_o), .mark_found_n_o(mark_found_n_o), .data_match_pulse_n_o(data_match_pulse_n_o),
    .clock_match_pulse_n_o(clock_match_pulse_n_o), .spare_latch_out_o(spare_latch_out_o),
    .stream_valid_o(stream_valid_o), .stream_bit_o(stream_bit_o), .stream_overrun_o(stream_overrun_o));
  smd_sep_model smd_sep_model_i (.clk_i(clk_i), .read_clk_o(read_clk_i), .read_clk_n_o(read_clk_n_i),
    .data_pulse_o(data_pulse_i), .clock_pulse_o(clock_pulse_i));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  always @(negedge clk_i) begin
    if (data_match_pulse_n_o === 1'b0) n_dp++;
    if (clock_match_pulse_n_o === 1'b0) n_cp++;
  end
  // ====================
  // Helpers
  // Stream starts with the mark byte's lower seven bits, then the new data
  function automatic logic exp_out(input int k);
    return (k < 7) ? smd_pkg::MARK_DATA[6-k] : post[22-k];
  endfunction
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // ====================
  // Scenarios
  initial begin
    void'($urandom(48));
    wait_clk(4);
    rst_n_i <= 1'b1;
    wait_clk(1);
    `CHK("mark_n reset", 1'b1, mark_found_n_o)
    `CHK("spare reset", 1'b1, spare_latch_out_o)
    smd_sep_model_i.send({8'h00, smd_pkg::MARK_DATA}, {8'h00, smd_pkg::MARK_CLOCK}, 16);
    wait_clk(4);
    `CHK("mark while off", 1'b0, mark_found_o)
    `CHK("pulses while off", 0, n_dp + n_cp)
    search_enable_i <= 1'b1;
    wait_clk(4);
    smd_sep_model_i.send({8'($urandom), smd_pkg::MARK_DATA}, 16'h0000, 16);
    wait_clk(4);
    `CHK("mark data only", 1'b0, mark_found_o)
    `CHK("data hit", 1'b1, n_dp > 0)
    `CHK("clock hit", 0, n_cp)
    smd_sep_model_i.send({8'h00, smd_pkg::MARK_DATA}, {8'h00, smd_pkg::MARK_CLOCK}, 8);
    wait_clk(4);
    `CHK("mark", 1'b1, mark_found_o)
    `CHK("mark_n", 1'b0, mark_found_n_o)
    `CHK("clock hit", 1'b1, n_cp > 0)
    `CHK("strobe", 1'b1, serial_out_strobe_o)
    // Downstream stalls through the whole burst, so the buffer must refuse
    post = 16'($urandom);
    smd_sep_model_i.send(post, 16'($urandom), 16);
    wait_clk(4);
    `CHK("overrun", 1'b1, stream_overrun_o)
    `CHK("serial", post[7], serial_data_o)
    `CHK("mark held", 1'b1, mark_found_o)
    for (int i = 0; i < 200 && got.size() < 9; i++) begin
      @(posedge clk_i);
      stream_ready_i <= 1'($urandom);
      @(negedge clk_i);
      if (stream_valid_o === 1'b1 && stream_ready_i === 1'b1) got.push_back(stream_bit_o);
    end
    // A stalled stream counts once; whatever did arrive is still compared
    if (got.size() < 9) n_mismatch++;
    foreach (got[k]) `CHK("stream", exp_out(k), got[k])
    wait_clk(1);
    stream_ready_i <= 1'b0;
    wait_clk(4);
    `CHK("drained", 1'b0, stream_valid_o)
    search_enable_i <= 1'b0;
    wait_clk(5);
    `CHK("mark cleared", 1'b1, mark_found_n_o)
    `CHK("overrun cleared", 1'b0, stream_overrun_o)
    `CHK("strobe off", 1'b0, serial_out_strobe_o)
    `CHK("serial off", 1'b0, serial_data_o)
    foreach (sp[i]) begin
      spare_latch_clock_i <= sp[i][2];
      spare_latch_clear_n_i <= sp[i][1];
      wait_clk(8);
      `CHK("spare", sp[i][0], spare_latch_out_o)
    end
    stop_test();
  end
endmodule
